// ===== logic/sbc_bank.sv
// state of one bank: bursts, auto precharge and recovery timers
`timescale 1ns/10ps
module sbc_bank (
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             en_i,
	input  sbc_pkg::sbc_cmd_e     cmd_i,
	input  wire logic             hit_i,
	input  wire logic             other_rw_i,
	input  wire logic             ap_i,
	input  wire logic [2:0]       burst_length_i,
	input  wire logic             single_wr_i,
	output sbc_pkg::sbc_bank_e    state_o,
	output logic                  rd_issue_o,
	output logic                  wr_issue_o,
	output logic                  pre_start_o
);

	sbc_pkg::sbc_bank_e state_r, state_nxt;
	logic [3:0]         cnt_r, cnt_nxt;
	logic               cont_r, cont_nxt;
	logic [7:0]         tmr_r, tmr_nxt;
	logic               pre_r, pre_nxt;
	logic               last;

	assign last = !cont_r && (cnt_r == 4'h1);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		cont_nxt  = cont_r;
		tmr_nxt   = tmr_r;
		pre_nxt   = 1'b0;
		// one column per cycle while a burst runs
		if (state_r inside {sbc_pkg::BK_READ, sbc_pkg::BK_WRITE,
			sbc_pkg::BK_READ_AP, sbc_pkg::BK_WRITE_AP}) begin
			if (!cont_r)
				cnt_nxt = cnt_r - 4'h1;
			if (last) begin
				case (state_r)
					sbc_pkg::BK_READ_AP: begin
						state_nxt = sbc_pkg::BK_PRECHG;
						tmr_nxt   = sbc_pkg::RP_CYC;
						pre_nxt   = 1'b1;
					end
					sbc_pkg::BK_WRITE_AP: begin
						state_nxt = sbc_pkg::BK_WR_RECOV;
						tmr_nxt   = sbc_pkg::WR_CYC;
					end
					default: state_nxt = sbc_pkg::BK_ACTIVE;
				endcase
			end
		end
		// timed states count down
		if (state_r == sbc_pkg::BK_WR_RECOV) begin
			tmr_nxt = tmr_r - 8'h1;
			if (tmr_r <= 8'h1) begin
				state_nxt = sbc_pkg::BK_PRECHG;
				tmr_nxt   = sbc_pkg::RP_CYC;
				pre_nxt   = 1'b1;
			end
		end
		if (state_r == sbc_pkg::BK_PRECHG) begin
			tmr_nxt = tmr_r - 8'h1;
			if (tmr_r <= 8'h1)
				state_nxt = sbc_pkg::BK_IDLE;
		end
		// access to another bank cuts this burst short
		if (other_rw_i) begin
			case (state_r)
				sbc_pkg::BK_READ, sbc_pkg::BK_WRITE:
					state_nxt = sbc_pkg::BK_ACTIVE;
				sbc_pkg::BK_READ_AP: begin
					state_nxt = sbc_pkg::BK_PRECHG;
					tmr_nxt   = sbc_pkg::RP_CYC;
					pre_nxt   = 1'b1;
				end
				sbc_pkg::BK_WRITE_AP: begin
					state_nxt = sbc_pkg::BK_WR_RECOV;
					tmr_nxt   = sbc_pkg::WR_CYC;
				end
				default: ;
			endcase
		end
		// commands addressed to this bank
		if (hit_i) begin
			case (cmd_i)
				sbc_pkg::CMD_ACT:
					if (state_r == sbc_pkg::BK_IDLE)
						state_nxt = sbc_pkg::BK_ACTIVE;
				sbc_pkg::CMD_READ, sbc_pkg::CMD_WRITE:
					if (state_r inside {sbc_pkg::BK_ACTIVE,
						sbc_pkg::BK_READ, sbc_pkg::BK_WRITE}) begin
						if (cmd_i == sbc_pkg::CMD_READ)
							state_nxt = ap_i ? sbc_pkg::BK_READ_AP
								: sbc_pkg::BK_READ;
						else
							state_nxt = ap_i ? sbc_pkg::BK_WRITE_AP
								: sbc_pkg::BK_WRITE;
						cont_nxt = (burst_length_i == sbc_pkg::BL_CONT);
						cnt_nxt  = sbc_pkg::burst_cols(burst_length_i);
						if (cmd_i == sbc_pkg::CMD_WRITE && single_wr_i) begin
							cont_nxt = 1'b0;
							cnt_nxt  = 4'h1;
						end
					end
				sbc_pkg::CMD_BT:
					if (state_r inside {sbc_pkg::BK_READ,
						sbc_pkg::BK_WRITE})
						state_nxt = sbc_pkg::BK_ACTIVE;
				sbc_pkg::CMD_PRE:
					if (state_r inside {sbc_pkg::BK_ACTIVE,
						sbc_pkg::BK_READ, sbc_pkg::BK_WRITE}) begin
						state_nxt = sbc_pkg::BK_PRECHG;
						tmr_nxt   = sbc_pkg::RP_CYC;
						pre_nxt   = 1'b1;
					end
				default: ; // nop and inhibit keep going
			endcase
		end
	end

	// ---------------------------------------------------------------
	// registers, frozen while not enabled
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_r <= sbc_pkg::BK_IDLE;
			cnt_r   <= 4'h0;
			cont_r  <= 1'b0;
			tmr_r   <= 8'h0;
			pre_r   <= 1'b0;
		end else if (en_i) begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			cont_r  <= cont_nxt;
			tmr_r   <= tmr_nxt;
			pre_r   <= pre_nxt;
		end
	end

	assign state_o     = state_r;
	assign pre_start_o = pre_r;
	assign rd_issue_o  = state_r inside {sbc_pkg::BK_READ,
		sbc_pkg::BK_READ_AP};
	assign wr_issue_o  = state_r inside {sbc_pkg::BK_WRITE,
		sbc_pkg::BK_WRITE_AP};

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	// checks sample on the rising clock and stay quiet in reset
	default clocking bank_cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	chk_single_write: assert property (
		en_i && hit_i && cmd_i == sbc_pkg::CMD_WRITE && single_wr_i
		&& state_r == sbc_pkg::BK_ACTIVE |=> cnt_r == 4'h1 && !cont_r)
		else $error("single write burst not one column");
	chk_rap_read_cut: assert property (
		en_i && other_rw_i && cmd_i == sbc_pkg::CMD_READ
		&& state_r == sbc_pkg::BK_READ_AP
		|=> state_r == sbc_pkg::BK_PRECHG && pre_start_o)
		else $error("read did not start precharge of cut bank");
	chk_rap_write_cut: assert property (
		en_i && other_rw_i && cmd_i == sbc_pkg::CMD_WRITE
		&& state_r == sbc_pkg::BK_READ_AP |=> !rd_issue_o && pre_start_o)
		else $error("write did not end auto precharge read");
	chk_wap_recover: assert property (
		en_i && other_rw_i && state_r == sbc_pkg::BK_WRITE_AP
		|=> state_r == sbc_pkg::BK_WR_RECOV && tmr_r == sbc_pkg::WR_CYC)
		else $error("write recovery not started at interrupt");
	chk_wap_last_data: assert property (
		en_i && other_rw_i && state_r == sbc_pkg::BK_WRITE_AP
		|=> !wr_issue_o)
		else $error("interrupted bank still takes write data");
	chk_wr_recov_pre: assert property (
		en_i && state_r == sbc_pkg::BK_WR_RECOV && tmr_r == 8'h1
		|=> state_r == sbc_pkg::BK_PRECHG && pre_start_o)
		else $error("precharge not begun after write recovery");

endmodule

// ===== logic/sbc_core.sv
// command decode, clock-gate power states and four bank trackers
`timescale 1ns/10ps
module sbc_core #(
	parameter int NUM_BANKS = 4
) (
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             ce_i,
	input  wire logic             cke_i,
	input  sbc_pkg::sbc_pins_s    pins_i,
	input  wire logic [1:0]       bank_i,
	input  wire logic             a10_i,
	input  wire logic             write_burst_mode_bit_i,
	input  wire logic [2:0]       burst_length_i,
	input  wire logic [1:0]       read_latency_i,
	output sbc_pkg::sbc_pwr_e     pwr_state_o,
	output logic [3*NUM_BANKS-1:0] bank_state_o,
	output logic [NUM_BANKS-1:0]  pre_start_o,
	output logic                  all_idle_o,
	output logic                  rd_valid_o,
	output logic                  wr_capture_o
);

	// ---------------------------------------------------------------
	// pin synchroniser, two flops
	// ---------------------------------------------------------------
	sbc_pkg::sbc_req_s  meta_r, req_r;
	sbc_pkg::sbc_req_s  raw;

	assign raw = '{pins: pins_i, bank: bank_i, a10: a10_i, cke: cke_i};

	// first flop feeds only the second
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			meta_r <= sbc_pkg::REQ_IDLE;
			req_r  <= sbc_pkg::REQ_IDLE;
		end else if (ce_i) begin
			meta_r <= raw;
			req_r  <= meta_r;
		end
	end

	// ---------------------------------------------------------------
	// decode and bank trackers
	// ---------------------------------------------------------------
	sbc_pkg::sbc_pwr_e  pwr_r, pwr_nxt;
	logic               cke_prev_r, cke_prev_nxt;
	logic [7:0]         xsr_r, xsr_nxt;
	sbc_pkg::sbc_cmd_e  cmd_raw, cmd_exec;
	logic               bank_en, exec, all_idle, any_burst;
	sbc_pkg::sbc_bank_e bstate [NUM_BANKS];
	logic [NUM_BANKS-1:0] rd_iss, wr_iss, pre_st;

	assign cmd_raw  = sbc_pkg::decode(req_r.pins);
	// banks advance only on normal, ungated edges
	assign bank_en  = ce_i && pwr_r == sbc_pkg::PW_NORMAL && req_r.cke;
	assign exec     = bank_en && cke_prev_r;
	assign cmd_exec = exec ? cmd_raw : sbc_pkg::CMD_NOP;

	genvar g;
	generate
		for (g = 0; g < NUM_BANKS; g++) begin : gen_bank
			logic hit, other;
			// precharge with a10 high addresses every bank
			assign hit = (req_r.bank == 2'(g))
				|| (cmd_exec == sbc_pkg::CMD_PRE && req_r.a10);
			assign other = (req_r.bank != 2'(g))
				&& (cmd_exec == sbc_pkg::CMD_READ
				|| cmd_exec == sbc_pkg::CMD_WRITE);
			sbc_bank u_bank (
				.clk_i          (clk_i),
				.rst_b_i        (rst_b_i),
				.en_i           (bank_en),
				.cmd_i          (cmd_exec),
				.hit_i          (hit),
				.other_rw_i     (other),
				.ap_i           (req_r.a10),
				.burst_length_i (burst_length_i),
				.single_wr_i    (write_burst_mode_bit_i),
				.state_o        (bstate[g]),
				.rd_issue_o     (rd_iss[g]),
				.wr_issue_o     (wr_iss[g]),
				.pre_start_o    (pre_st[g])
			);
			assign bank_state_o[3*g +: 3] = bstate[g];
		end
	endgenerate

	assign pre_start_o = pre_st;

	// all banks idle and no burst running
	always_comb begin
		all_idle  = 1'b1;
		any_burst = 1'b0;
		for (int i = 0; i < NUM_BANKS; i++) begin
			if (bstate[i] != sbc_pkg::BK_IDLE)
				all_idle = 1'b0;
			if (rd_iss[i] || wr_iss[i])
				any_burst = 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// clock-gate power state machine
	// ---------------------------------------------------------------
	always_comb begin
		pwr_nxt      = pwr_r;
		xsr_nxt      = xsr_r;
		cke_prev_nxt = req_r.cke;
		case (pwr_r)
			sbc_pkg::PW_NORMAL:
				if (cke_prev_r && !req_r.cke) begin
					if (any_burst)
						pwr_nxt = sbc_pkg::PW_SUSPEND;
					else if (all_idle && cmd_raw == sbc_pkg::CMD_BT)
						pwr_nxt = sbc_pkg::PW_DEEP;
					else if (all_idle && cmd_raw == sbc_pkg::CMD_REF)
						pwr_nxt = sbc_pkg::PW_SELF;
					else if (sbc_pkg::is_nop(cmd_raw))
						pwr_nxt = sbc_pkg::PW_DOWN;
				end
			// gate still low holds state; gate high with nop or inhibit exits
			sbc_pkg::PW_DOWN:
				if (req_r.cke && sbc_pkg::is_nop(cmd_raw))
					pwr_nxt = sbc_pkg::PW_NORMAL;
			sbc_pkg::PW_SELF:
				if (req_r.cke && sbc_pkg::is_nop(cmd_raw)) begin
					pwr_nxt = sbc_pkg::PW_SR_EXIT;
					xsr_nxt = sbc_pkg::XSR_CYC;
				end
			sbc_pkg::PW_SR_EXIT: begin
				xsr_nxt = xsr_r - 8'h1;
				if (xsr_r <= 8'h1)
					pwr_nxt = sbc_pkg::PW_NORMAL;
			end
			sbc_pkg::PW_SUSPEND, sbc_pkg::PW_DEEP:
				if (req_r.cke)
					pwr_nxt = sbc_pkg::PW_NORMAL;
			default: pwr_nxt = sbc_pkg::PW_NORMAL;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pwr_r      <= sbc_pkg::PW_NORMAL;
			xsr_r      <= 8'h0;
			cke_prev_r <= 1'b1;
		end else if (ce_i) begin
			pwr_r      <= pwr_nxt;
			xsr_r      <= xsr_nxt;
			cke_prev_r <= cke_prev_nxt;
		end
	end

	// ---------------------------------------------------------------
	// data strobes
	// ---------------------------------------------------------------
	logic rd_pipe_r, rd_pipe_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic wr_cap_r, wr_cap_nxt;
	logic idle_r;

	// read data leaves after latency 2 unless latency 3 is set; a write flushes it
	always_comb begin
		rd_pipe_nxt  = |rd_iss;
		rd_valid_nxt = (read_latency_i == sbc_pkg::RL_3)
			? rd_pipe_r : |rd_iss;
		wr_cap_nxt   = |wr_iss;
		if (cmd_exec == sbc_pkg::CMD_WRITE) begin
			rd_pipe_nxt  = 1'b0;
			rd_valid_nxt = 1'b0;
		end
	end

	// frozen during clock suspend so read data stays driven
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rd_pipe_r  <= 1'b0;
			rd_valid_r <= 1'b0;
			wr_cap_r   <= 1'b0;
			idle_r     <= 1'b1;
		end else if (ce_i) begin
			idle_r <= all_idle;
			if (bank_en) begin
				rd_pipe_r  <= rd_pipe_nxt;
				rd_valid_r <= rd_valid_nxt;
				wr_cap_r   <= wr_cap_nxt;
			end
		end
	end

	assign pwr_state_o  = pwr_r;
	assign all_idle_o   = idle_r;
	assign rd_valid_o   = rd_valid_r;
	assign wr_capture_o = wr_cap_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	// checks sample on the rising clock and stay quiet in reset
	default clocking core_cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	chk_deep_pd_entry: assert property (
		ce_i && pwr_r == sbc_pkg::PW_NORMAL && cke_prev_r && !req_r.cke
		&& !any_burst && all_idle && cmd_raw == sbc_pkg::CMD_BT
		|=> pwr_r == sbc_pkg::PW_DEEP)
		else $error("deep power-down not entered");
	chk_pd_exit: assert property (
		ce_i && pwr_r == sbc_pkg::PW_DOWN && req_r.cke
		&& sbc_pkg::is_nop(cmd_raw) |=> pwr_r == sbc_pkg::PW_NORMAL)
		else $error("power-down exit late");
	chk_suspend_exit: assert property (
		ce_i && pwr_r == sbc_pkg::PW_SUSPEND && req_r.cke
		##1 ce_i && req_r.cke |-> exec)
		else $error("command not decoded after suspend exit");
	chk_suspend_entry: assert property (
		ce_i && pwr_r == sbc_pkg::PW_NORMAL && cke_prev_r && !req_r.cke
		&& any_burst |=> pwr_r == sbc_pkg::PW_SUSPEND && $stable(bstate[0]))
		else $error("clock suspend not entered");
	chk_self_ref_entry: assert property (
		ce_i && pwr_r == sbc_pkg::PW_NORMAL && cke_prev_r && !req_r.cke
		&& !any_burst && all_idle && cmd_raw == sbc_pkg::CMD_REF
		|=> pwr_r == sbc_pkg::PW_SELF)
		else $error("self refresh not entered");

endmodule

// ===== logic/sbc_pkg.sv
// shared types, constants and decode helpers for the bank command logic
package sbc_pkg;

	// ---------------------------------------------------------------
	// timing, in ns as specified and in cycles of the 100 MHz clock
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS        = 10;
	localparam int WRITE_RECOVERY_NS    = 15;
	localparam int PRECHARGE_PERIOD_NS  = 20;
	localparam int SELF_REFRESH_EXIT_NS = 120;

	// least times round up to whole cycles
	localparam logic [7:0] WR_CYC  = 8'((WRITE_RECOVERY_NS
		+ CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] RP_CYC  = 8'((PRECHARGE_PERIOD_NS
		+ CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] XSR_CYC = 8'((SELF_REFRESH_EXIT_NS
		+ CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ---------------------------------------------------------------
	// mode fields
	// ---------------------------------------------------------------
	localparam logic [2:0] BL_1    = 3'h0;
	localparam logic [2:0] BL_2    = 3'h1;
	localparam logic [2:0] BL_4    = 3'h2;
	localparam logic [2:0] BL_8    = 3'h3;
	localparam logic [2:0] BL_CONT = 3'h7;
	localparam logic [1:0] RL_3    = 2'h3;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		CMD_INHIBIT = 4'h0,
		CMD_NOP     = 4'h1,
		CMD_ACT     = 4'h2,
		CMD_READ    = 4'h3,
		CMD_WRITE   = 4'h4,
		CMD_BT      = 4'h5,
		CMD_PRE     = 4'h6,
		CMD_REF     = 4'h7,
		CMD_LMR     = 4'h8
	} sbc_cmd_e;

	typedef enum logic [2:0] {
		BK_IDLE     = 3'h0,
		BK_ACTIVE   = 3'h1,
		BK_READ     = 3'h3,
		BK_WRITE    = 3'h2,
		BK_READ_AP  = 3'h6,
		BK_WRITE_AP = 3'h7,
		BK_WR_RECOV = 3'h5,
		BK_PRECHG   = 3'h4
	} sbc_bank_e;

	typedef enum logic [2:0] {
		PW_NORMAL  = 3'h0,
		PW_DOWN    = 3'h1,
		PW_SUSPEND = 3'h3,
		PW_SELF    = 3'h2,
		PW_SR_EXIT = 3'h6,
		PW_DEEP    = 3'h7
	} sbc_pwr_e;

	typedef struct packed {
		logic cs_b;
		logic ras_b;
		logic cas_b;
		logic we_b;
	} sbc_pins_s;

	typedef struct packed {
		sbc_pins_s  pins;
		logic [1:0] bank;
		logic       a10;
		logic       cke;
	} sbc_req_s;

	localparam sbc_req_s REQ_IDLE = '{pins: 4'hF, bank: 2'h0,
		a10: 1'b0, cke: 1'b1};

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic sbc_cmd_e decode(input sbc_pins_s p);
		sbc_cmd_e c;
		c = CMD_NOP;
		if (p.cs_b)
			c = CMD_INHIBIT;
		else case ({p.ras_b, p.cas_b, p.we_b})
			3'h7: c = CMD_NOP;
			3'h3: c = CMD_ACT;
			3'h5: c = CMD_READ;
			3'h4: c = CMD_WRITE;
			3'h6: c = CMD_BT;
			3'h2: c = CMD_PRE;
			3'h1: c = CMD_REF;
			default: c = CMD_LMR;
		endcase
		return c;
	endfunction

	function automatic logic is_nop(input sbc_cmd_e c);
		return (c == CMD_NOP) || (c == CMD_INHIBIT);
	endfunction

	function automatic logic [3:0] burst_cols(input logic [2:0] code);
		logic [3:0] n;
		n = 4'h1;
		case (code)
			BL_2:    n = 4'h2;
			BL_4:    n = 4'h4;
			BL_8:    n = 4'h8;
			default: n = 4'h1;
		endcase
		return n;
	endfunction

endpackage

// ===== sim/sbc_core_tb.sv
// bench for the bank command logic: scenarios and result checks
`timescale 1ns/10ps
module sbc_core_tb;
	localparam logic [3:0] P_INH = 4'hF;
	localparam logic [3:0] P_ACT = 4'h3;
	localparam logic [3:0] P_RD  = 4'h5;
	localparam logic [3:0] P_WR  = 4'h4;
	localparam logic [3:0] P_BT  = 4'h6;
	localparam logic [3:0] P_PRE = 4'h2;
	localparam logic [3:0] P_REF = 4'h1;
	logic               clk_i;
	logic               rst_b_i;
	logic               ce_i;
	logic               write_burst_mode_bit;
	logic [2:0]         burst_length;
	logic [1:0]         read_latency;
	sbc_pkg::sbc_pins_s pins;
	logic [1:0]         bank;
	logic               a10;
	logic               cke;
	sbc_pkg::sbc_pwr_e  pwr;
	logic [11:0]        bk_st;
	logic [3:0]         pre_st;
	logic               all_idle;
	logic               rd_v;
	logic               wr_c;
	logic [3:0]         exp_q[$];
	logic [3:0]         act;
	int                 n_fail;
	int                 cmp_count;
	int                 c;
	int                 n;
	int                 m;

	sbc_core #(
		.NUM_BANKS (4)
	) u_dut (
		.clk_i                  (clk_i),
		.rst_b_i                (rst_b_i),
		.ce_i                   (ce_i),
		.cke_i                  (cke),
		.pins_i                 (pins),
		.bank_i                 (bank),
		.a10_i                  (a10),
		.write_burst_mode_bit_i (write_burst_mode_bit),
		.burst_length_i         (burst_length),
		.read_latency_i         (read_latency),
		.pwr_state_o            (pwr),
		.bank_state_o           (bk_st),
		.pre_start_o            (pre_st),
		.all_idle_o             (all_idle),
		.rd_valid_o             (rd_v),
		.wr_capture_o           (wr_c)
	);

	sbc_ctrl_model u_ctrl (
		.clk_i  (clk_i),
		.pins_o (pins),
		.bank_o (bank),
		.a10_o  (a10),
		.cke_o  (cke)
	);

	// 100 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// ---------------------------------------------------------------
	// checking helpers
	// ---------------------------------------------------------------
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %0h seen %0h", nm, e, g);
		end
	endtask

	// bounded wait for a bank (0..3) or power (4) state; cy = cycles
	task automatic wait_for(input int s, input logic [2:0] e,
		output int cy);
		logic [2:0] g;
		for (cy = 0; cy < 40; cy++) begin
			g = (s == 4) ? pwr : bk_st[3*s+:3];
			if (g === e)
				return;
			@(negedge clk_i);
		end
		chk("state wait", e, g);
		finish_test();
	endtask

	task automatic act_bank(input int b);
		u_ctrl.cmd(P_ACT, 2'(b), 1'b0, 1'b1);
		u_ctrl.nop(1'b1);
		wait_for(b, sbc_pkg::BK_ACTIVE, c);
		act[b] = 1'b1;
	endtask

	// one access to bank 0 at a random latency, columns of data counted
	task automatic burst(input logic [3:0] p, input int er,
		input int ew);
		int r;
		int w;
		int f;
		r = 0;
		w = 0;
		f = -1;
		read_latency = 2'($urandom);
		u_ctrl.cmd(p, 2'h0, 1'b0, 1'b1);
		u_ctrl.nop(1'b1);
		for (int k = 0; k < 16; k++) begin
			@(negedge clk_i);
			if (rd_v && f < 0)
				f = k;
			r += rd_v;
			w += wr_c;
		end
		chk("read columns", er, r);
		chk("write columns", ew, w);
		// first data two sync edges plus two, or three at latency 3, after the pins
		if (er > 0)
			chk("read latency", (read_latency == sbc_pkg::RL_3)
				? 16'h3 : 16'h2, f);
	endtask

	// precharge pulses are results: each takes the oldest note
	always @(negedge clk_i) begin
		if (rst_b_i && pre_st !== 4'h0) begin
			if (exp_q.size() == 0)
				chk("pre_start", 4'h0, pre_st);
			else
				chk("pre_start", exp_q.pop_front(), pre_st);
		end
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		rst_b_i = 1'b0;
		ce_i = 1'b1;
		write_burst_mode_bit = 1'b0;
		burst_length = 3'h1;
		read_latency = 2'h2;
		n_fail = 0;
		cmp_count = 0;
		act = 4'h0;
		c = $urandom(32'h89f58174);
		repeat (16) @(negedge clk_i);
		rst_b_i = 1'b1;
		chk("reset state", 16'h8000, {all_idle, pwr, bk_st});
		act_bank(0);
		burst(P_RD, 2, 0);
		write_burst_mode_bit = 1'b1;
		burst_length = 3'h2;
		burst(P_WR, 0, 1);
		write_burst_mode_bit = 1'($urandom);
		burst(P_RD, 4, 0);
		write_burst_mode_bit = 1'b0;
		burst(P_WR, 0, 4);
		u_ctrl.cmd(P_INH, 2'h0, 1'b1, 1'b1);
		u_ctrl.nop(1'b1);
		repeat (4) @(negedge clk_i);
		chk("bank after nop", sbc_pkg::BK_ACTIVE, bk_st[2:0]);
		// read cut by terminate, write cut by precharge
		burst_length = 3'h3;
		u_ctrl.cmd(P_RD, 2'h0, 1'b0, 1'b1);
		u_ctrl.cmd(P_BT, 2'h0, 1'b0, 1'b1);
		u_ctrl.nop(1'b1);
		repeat (4) @(negedge clk_i);
		chk("read cut", sbc_pkg::BK_ACTIVE, bk_st[2:0]);
		u_ctrl.cmd(P_WR, 2'h0, 1'b0, 1'b1);
		exp_q.push_back(4'h1);
		u_ctrl.cmd(P_PRE, 2'h0, 1'b0, 1'b1);
		u_ctrl.nop(1'b1);
		wait_for(0, sbc_pkg::BK_PRECHG, c);
		wait_for(0, sbc_pkg::BK_IDLE, c);
		chk("precharge cycles", sbc_pkg::RP_CYC, c);
		act[0] = 1'b0;
		// auto precharge access on bank n cut by access to bank m
		for (int i = 0; i < 4; i++) begin
			n = $urandom % 4;
			m = (n + 1 + $urandom % 3) % 4;
			if (!act[n])
				act_bank(n);
			if (!act[m])
				act_bank(m);
			u_ctrl.cmd(i[1] ? P_WR : P_RD, 2'(n), 1'b1, 1'b1);
			u_ctrl.nop(1'b1);  // gap leaves room to mask data
			if (!i[1])
				exp_q.push_back(4'h1 << n);
			u_ctrl.cmd(i[0] ? P_WR : P_RD, 2'(m), 1'b0, 1'b1);
			u_ctrl.nop(1'b1);
			if (i[1]) begin
				wait_for(n, sbc_pkg::BK_WR_RECOV, c);
				exp_q.push_back(4'h1 << n);
				wait_for(n, sbc_pkg::BK_PRECHG, c);
				chk("recovery cycles", sbc_pkg::WR_CYC, c);
			end else
				wait_for(n, sbc_pkg::BK_PRECHG, c);
			chk("other bank", i[0] ? sbc_pkg::BK_WRITE : sbc_pkg::BK_READ,
				bk_st[3*m+:3]);
			wait_for(n, sbc_pkg::BK_IDLE, c);
			wait_for(m, sbc_pkg::BK_ACTIVE, c);
			act[n] = 1'b0;
			act[m] = 1'b1;
		end
		// enable low: a precharge-all on the pins is never sampled
		ce_i = 1'b0;
		u_ctrl.cmd(P_PRE, 2'h0, 1'b1, 1'b1);
		u_ctrl.nop(1'b1);
		repeat ($urandom % 4) @(negedge clk_i);
		ce_i = 1'b1;
		repeat (6) @(negedge clk_i);
		chk("enable freeze", 1'b0, all_idle);
		exp_q.push_back(act);
		u_ctrl.cmd(P_PRE, 2'h0, 1'b1, 1'b1);
		u_ctrl.nop(1'b1);
		repeat (8) @(negedge clk_i);
		chk("all idle", 1'b1, all_idle);
		// power-down, exit, command on the next edge
		u_ctrl.nop(1'b0);
		wait_for(4, sbc_pkg::PW_DOWN, c);
		u_ctrl.nop(1'b1);
		u_ctrl.cmd(P_ACT, 2'h1, 1'b0, 1'b1);
		u_ctrl.nop(1'b1);
		wait_for(1, sbc_pkg::BK_ACTIVE, c);
		exp_q.push_back(4'h2);
		u_ctrl.cmd(P_PRE, 2'h1, 1'b0, 1'b1);
		u_ctrl.nop(1'b1);
		wait_for(1, sbc_pkg::BK_IDLE, c);
		// self refresh and its exit time
		u_ctrl.cmd(P_REF, 2'h0, 1'b0, 1'b0);
		u_ctrl.nop(1'b0);
		wait_for(4, sbc_pkg::PW_SELF, c);
		u_ctrl.nop(1'b1);
		wait_for(4, sbc_pkg::PW_SR_EXIT, c);
		wait_for(4, sbc_pkg::PW_NORMAL, c);
		chk("exit cycles", sbc_pkg::XSR_CYC, c);
		// deep power-down, then the wake-up sequence
		u_ctrl.cmd(P_BT, 2'h0, 1'b0, 1'b0);
		u_ctrl.nop(1'b0);
		wait_for(4, sbc_pkg::PW_DEEP, c);
		u_ctrl.nop(1'b1);
		wait_for(4, sbc_pkg::PW_NORMAL, c);
		repeat (10000) @(negedge clk_i);
		u_ctrl.cmd(P_PRE, 2'h0, 1'b1, 1'b1);
		u_ctrl.cmd(P_REF, 2'h0, 1'b0, 1'b1);
		u_ctrl.nop(1'b1);
		u_ctrl.cmd(P_REF, 2'h0, 1'b0, 1'b1);
		u_ctrl.nop(1'b1);
		// clock suspend in a continuous read, left with a command
		burst_length = 3'h7;
		act_bank(0);
		u_ctrl.cmd(P_RD, 2'h0, 1'b0, 1'b1);
		u_ctrl.nop(1'b0);
		wait_for(4, sbc_pkg::PW_SUSPEND, c);
		repeat (3) @(negedge clk_i);
		chk("frozen bank", sbc_pkg::BK_READ, bk_st[2:0]);
		u_ctrl.cmd(P_BT, 2'h0, 1'b0, 1'b1);
		u_ctrl.cmd(P_BT, 2'h0, 1'b0, 1'b1);
		u_ctrl.nop(1'b1);
		wait_for(0, sbc_pkg::BK_ACTIVE, c);
		repeat (4) @(negedge clk_i);
		chk("pending notes", 16'h0, 16'(exp_q.size()));
		finish_test();
	end
endmodule

// ===== sim/sbc_ctrl_model.sv
// controller model: drives strobes, bank, a10 and the clock gate
`timescale 1ns/10ps
module sbc_ctrl_model (
	input  wire logic          clk_i,
	output sbc_pkg::sbc_pins_s pins_o,
	output logic [1:0]         bank_o,
	output logic               a10_o,
	output logic               cke_o
);
	// idle lines at time zero: inhibit, gate high
	initial begin
		pins_o = 4'hF;
		bank_o = 2'h0;
		a10_o  = 1'b0;
		cke_o  = 1'b1;
	end

	// one defined command for one cycle, set off the sampling edge
	task automatic cmd(input logic [3:0] p, input logic [1:0] b,
		input logic a, input logic k);
		@(negedge clk_i);
		pins_o = p;
		bank_o = b;
		a10_o  = a;
		cke_o  = k;
	endtask

	// nop cycle; unqualified address lines keep changing
	task automatic nop(input logic k);
		@(negedge clk_i);
		pins_o = 4'h7;
		bank_o = ~bank_o;
		a10_o  = ~a10_o;
		cke_o  = k;
	endtask
endmodule
